/* File: upi_operator.sv */
// Behavioural model of the operator at the front-panel buttons.
// Assumes the bench clock. Presses stay far shorter than a two second hold.
`timescale 1ns/1ps
`default_nettype none
module upi_operator (
   input  wire logic clock,
   input  wire logic nrst,
   output var  logic on_button,
   output var  logic off_button
);
   integer seed = 32'hac7a;
   initial begin
      on_button = 1'b0;
      off_button = 1'b0;
   end
   // Random taps on either button; a real hold needs 16 timebase ticks, so none can fire.
   always @(posedge clock) begin
      if (nrst && ($random(seed) % 64 == 0)) begin
         on_button <= ~on_button;
      end
      if (nrst && ($random(seed) % 64 == 1)) begin
         off_button <= ~off_button;
      end
   end
endmodule
`default_nettype wire

/* File: upi_panel.sv */
// Front-panel indication and button logic: LEDs, bar graph, alarm, buttons.
// Assumes debounced, synchronous, active-high button levels and status inputs.
`timescale 1ns/1ps
`default_nettype none
module upi_panel (
   input  wire logic                    clock,
   input  wire logic                    nrst,
   input  wire logic                    on_button,
   input  wire logic                    off_button,
   input  wire upi_pkg::upi_status_type status,
   output var  upi_pkg::upi_leds_type   leds,
   output var  logic                    buzzer,
   output var  logic                    cmd_switch_on,
   output var  logic                    cmd_switch_off,
   output var  logic                    cmd_self_test,
   output var  logic                    serial_enable
);
   import upi_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Timebase: one tick every 125 ms, all slow timing counts ticks.
   logic [21:0] pre;
   logic        tick;
   logic [TW-1:0] slow;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pre  <= '0;
         tick <= 1'b0;
      end else if (pre == 22'(TICK_CYCLES - 1)) begin
         pre  <= '0;
         tick <= 1'b1;
      end else begin
         pre  <= pre + 22'h1;
         tick <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Button hold timers. A hold fires once; the button must be released before
   // it can fire again, so a long press never repeats a command.
   logic [4:0] on_cnt, off_cnt;
   logic       on_fire, off_fire;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         on_cnt <= '0;
      end else if (!on_button) begin
         on_cnt <= '0;
      end else if (tick && on_cnt <= 5'(HOLD_TICKS)) begin
         on_cnt <= on_cnt + 5'h1;
      end
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         off_cnt <= '0;
      end else if (!off_button) begin
         off_cnt <= '0;
      end else if (tick && off_cnt <= 5'(HOLD_TICKS)) begin
         off_cnt <= off_cnt + 5'h1;
      end
   end
   assign on_fire  = tick && on_button && on_cnt == 5'(HOLD_TICKS - 1);
   assign off_fire = tick && off_button && off_cnt == 5'(HOLD_TICKS - 1);

   ////////////////////////////////////////////////////////////////////////////
   // Alarm condition, most severe first.
   logic overload, bat_low, alarm_on, silenced, rearm, sounding;
   upi_alarm_type alarm, prev_alarm;
   assign overload = status.load_pct >= LOAD_OVL;
   assign bat_low  = status.on_battery && status.cap_pct <= CAP_LOW;
   always_comb begin
      if (status.fault)
         alarm = ALM_FAULT;
      else if (overload && (status.on_inverter || status.on_bypass))
         alarm = ALM_OVERLOAD;
      else if (bat_low)
         alarm = ALM_BAT_LOW;
      else if (status.on_battery)
         alarm = ALM_BAT;
      else if (status.on_bypass)
         alarm = ALM_BYPASS;
      else
         alarm = ALM_NONE;
   end
   assign alarm_on = alarm != ALM_NONE;
   // A worsening alarm counts as sounding in the very cycle that clears the silence,
   // so neither the tone nor the on button lags the re-arm by a cycle.
   assign rearm    = !alarm_on || alarm > prev_alarm;
   assign sounding = alarm_on && (!silenced || rearm);

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         prev_alarm <= ALM_NONE;
      end else begin
         prev_alarm <= alarm;
      end
   end

   // Silence holds until the condition worsens or clears.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         silenced <= 1'b0;
      end else if (rearm) begin
         silenced <= 1'b0;
      end else if (on_fire) begin
         silenced <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Commands: one-cycle pulses. The alarm-silence use of the on button takes
   // priority over switch-on and self-test.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cmd_switch_on  <= 1'b0;
         cmd_switch_off <= 1'b0;
         cmd_self_test  <= 1'b0;
      end else begin
         cmd_switch_off <= off_fire;
         cmd_switch_on  <= on_fire && !sounding && !status.unit_on;
         cmd_self_test  <= on_fire && !sounding && status.unit_on
                           && status.mains_ok && status.on_inverter;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Beep pattern: period counter in ticks, beep in the first tick(s).
   logic [TW-1:0] period;
   always_comb begin
      case (alarm)
         ALM_FAULT:    period = '0;
         ALM_OVERLOAD: period = TW'(PER_FAST_MS / TICK_MS);
         ALM_BAT_LOW:  period = TW'(PER_1S_MS / TICK_MS);
         ALM_BAT:      period = TW'(PER_4S_MS / TICK_MS);
         ALM_BYPASS:   period = TW'(PER_BYP_MS / TICK_MS);
         default:      period = '0;
      endcase
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         slow <= '0;
      end else if (alarm != prev_alarm) begin
         slow <= '0;
      end else if (tick) begin
         slow <= (slow + TW'(1) >= period) ? '0 : slow + TW'(1);
      end
   end
   // A fault gives a continuous tone.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         buzzer <= 1'b0;
      end else begin
         buzzer <= sounding &&
                   (alarm == ALM_FAULT || slow < TW'(BEEP_TICKS));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // LEDs.
   logic [2:0] flash_cnt;
   logic       flash;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         flash_cnt <= '0;
         flash     <= 1'b0;
      end else if (tick) begin
         if (flash_cnt == 3'(FLASH_MS / TICK_MS - 1)) begin
            flash_cnt <= '0;
            flash     <= !flash;
         end else begin
            flash_cnt <= flash_cnt + 3'h1;
         end
      end
   end

   logic [4:0] next_bar;
   always_comb begin
      next_bar = BAR_NONE;
      if (status.on_battery) begin
         next_bar[0] = 1'b1;
         next_bar[1] = status.cap_pct <= CAP_B4;
         next_bar[2] = status.cap_pct <= CAP_B3;
         next_bar[3] = status.cap_pct <= CAP_B2;
         next_bar[4] = status.cap_pct <= CAP_B1;
      end else if (status.mains_ok) begin
         next_bar[0] = 1'b1;
         next_bar[1] = status.load_pct > LOAD_B1;
         next_bar[2] = status.load_pct > LOAD_B2;
         next_bar[3] = status.load_pct > LOAD_B3;
         next_bar[4] = status.load_pct > LOAD_B4;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         leds          <= '0;
         serial_enable <= 1'b0;
      end else begin
         leds.bypass   <= status.on_bypass;
         leds.inverter <= status.on_inverter;
         leds.battery  <= status.on_battery;
         leds.mains    <= (status.mains_ok && !status.wiring_fault) ? 1'b1 : flash;
         leds.fault    <= status.fault || (overload && alarm == ALM_OVERLOAD);
         leds.bar      <= next_bar;
         serial_enable <= !status.slot_board;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   off_cmd_a: assert property (@(posedge clock) disable iff (!nrst)
      off_fire |=> cmd_switch_off) else $error("switch-off not issued");
   on_cmd_a: assert property (@(posedge clock) disable iff (!nrst)
      cmd_switch_on |-> $past(on_fire) && !$past(status.unit_on))
      else $error("switch-on without hold or while on");
   silence_a: assert property (@(posedge clock) disable iff (!nrst)
      on_fire && alarm_on && !silenced && alarm == prev_alarm |=> silenced)
      else $error("alarm not silenced");
   test_cmd_a: assert property (@(posedge clock) disable iff (!nrst)
      cmd_self_test |-> $past(status.mains_ok)) else $error("self-test off mains");
   bypass_led_a: assert property (@(posedge clock) disable iff (!nrst)
      ##1 leds.bypass == $past(status.on_bypass)) else $error("bypass led wrong");
   fault_led_a: assert property (@(posedge clock) disable iff (!nrst)
      status.fault |=> leds.fault && (silenced || buzzer))
      else $error("fault not shown");
   bar_fill_a: assert property (@(posedge clock) disable iff (!nrst)
      leds.bar[4] |-> leds.bar[3]) else $error("bar not cumulative");
   serial_off_a: assert property (@(posedge clock) disable iff (!nrst)
      status.slot_board |=> !serial_enable) else $error("serial not disabled");
   rearm_a: assert property (@(posedge clock) disable iff (!nrst)
      alarm > prev_alarm |=> !silenced) else $error("silence not re-armed");

   on_hold_c:   cover property (@(posedge clock) disable iff (!nrst) cmd_switch_on);
   off_hold_c:  cover property (@(posedge clock) disable iff (!nrst) cmd_switch_off);
   silenced_c:  cover property (@(posedge clock) disable iff (!nrst) silenced);
   bat_low_c:   cover property (@(posedge clock) disable iff (!nrst) alarm == ALM_BAT_LOW);
endmodule
`default_nettype wire

/* File: upi_panel_tb.sv */
// Self-checking bench for the front-panel indication and button logic.
// Assumes the package constants as declared; holds stay short of the two second count.
`timescale 1ns/1ps
`default_nettype none
module upi_panel_tb;
   import upi_pkg::*;
   logic           clock = 1'b0;
   logic           nrst = 1'b0;
   logic           on_button;
   logic           off_button;
   upi_status_type status = '0;
   upi_leds_type   leds;
   logic           buzzer;
   logic           cmd_switch_on;
   logic           cmd_switch_off;
   logic           cmd_self_test;
   logic           serial_enable;
   integer         n_errors = 0;
   integer         n_compared = 0;
   integer         seed = 32'hac7a;
   logic [6:0]     corner [0:16] = '{7'h00, 7'h14, 7'h15, 7'h19, 7'h1a, 7'h23, 7'h24, 7'h32,
                                     7'h33, 7'h37, 7'h38, 7'h4b, 7'h4c, 7'h5f, 7'h60, 7'h68,
                                     7'h69};

   always #20 clock = ~clock;

   upi_operator i_upi_operator (.clock(clock), .nrst(nrst), .on_button(on_button),
                                .off_button(off_button));
   upi_panel i_upi_panel (.clock(clock), .nrst(nrst), .on_button(on_button),
                          .off_button(off_button), .status(status), .leds(leds),
                          .buzzer(buzzer), .cmd_switch_on(cmd_switch_on),
                          .cmd_switch_off(cmd_switch_off), .cmd_self_test(cmd_self_test),
                          .serial_enable(serial_enable));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic upi_leds_type exp_leds(input upi_status_type s);
      upi_leds_type e;
      e.bypass = s.on_bypass;
      e.inverter = s.on_inverter;
      e.battery = s.on_battery;
      e.mains = s.mains_ok;
      e.fault = s.fault || ((s.load_pct >= LOAD_OVL) && (s.on_inverter || s.on_bypass));
      e.bar = BAR_NONE;
      if (s.on_battery) begin
         e.bar = {s.cap_pct <= CAP_B1, s.cap_pct <= CAP_B2, s.cap_pct <= CAP_B3,
                  s.cap_pct <= CAP_B4, 1'b1};
      end else if (s.mains_ok) begin
         e.bar = {s.load_pct > LOAD_B4, s.load_pct > LOAD_B3, s.load_pct > LOAD_B2,
                  s.load_pct > LOAD_B1, 1'b1};
      end
      return e;
   endfunction

   task automatic check(input logic ok, input string msg);
      n_compared = n_compared + 1;
      if (ok !== 1'b1) begin
         n_errors = n_errors + 1;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask

   task automatic results;
      if (n_errors == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Applies one status word, lets it settle and compares the LEDs, serial enable and, for a fault or no alarm, the buzzer.
   task automatic apply(input upi_status_type s);
      upi_leds_type e;
      upi_leds_type m;
      logic         quiet;
      e = exp_leds(s);
      m = '1;
      // The flash phase is free running, so a flashing mains lamp is left out.
      m.mains = s.mains_ok && !s.wiring_fault;
      quiet = !s.fault && !e.fault && !s.on_battery && !s.on_bypass;
      @(posedge clock);
      status <= s;
      repeat (3) @(posedge clock);
      @(negedge clock);
      check((leds & m) === (e & m), "led pattern");
      check(serial_enable === !s.slot_board, "serial enable");
      if (s.fault) begin
         check(buzzer === 1'b1, "fault tone");
      end
      if (quiet) begin
         check(buzzer === 1'b0, "silent when no alarm");
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   always @(negedge clock) begin
      if (nrst && (cmd_switch_on || cmd_switch_off || cmd_self_test) !== 1'b0) begin
         check(1'b0, "command before a full hold");
      end
   end

   initial begin
      #(40 * 60000);
      n_errors = n_errors + 1;
      $display("MISMATCH %0t watchdog expired", $time);
      results();
   end

   initial begin
      upi_status_type s;
      repeat (5) @(posedge clock);
      @(negedge clock);
      check({leds, buzzer, cmd_switch_on, cmd_switch_off, cmd_self_test, serial_enable}
            === 15'h0000, "outputs during reset");
      @(posedge clock);
      nrst <= 1'b1;
      for (int i = 0; i < 17; i++) begin
         for (int mode = 0; mode < 4; mode++) begin
            s = '0;
            s.mains_ok = (mode != 1);
            s.on_battery = (mode == 1);
            s.on_inverter = (mode != 2);
            s.on_bypass = (mode == 2);
            s.fault = (mode == 3);
            s.unit_on = 1'b1;
            s.slot_board = mode[0];
            s.load_pct = corner[i];
            s.cap_pct = corner[i];
            apply(s);
         end
      end
      for (int i = 0; i < 150; i++) begin
         s = upi_status_type'(22'($random(seed)));
         apply(s);
      end
      results();
   end
endmodule
`default_nettype wire

/* File: upi_pkg.sv */
// Constants and types for the front-panel indication and button logic.
// Assumes a single 25 MHz clock and status inputs already synchronous to it.
`default_nettype none
package upi_pkg;
   localparam int unsigned CLK_HZ       = 25_000_000;
   localparam int unsigned HOLD_MS      = 2000;
   localparam int unsigned TICK_MS      = 125;
   localparam int unsigned TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;
   localparam int unsigned HOLD_TICKS   = HOLD_MS / TICK_MS;
   localparam int unsigned BEEP_MS      = 125;
   localparam int unsigned BEEP_TICKS   = BEEP_MS / TICK_MS;
   localparam int unsigned PER_FAST_MS  = 500;
   localparam int unsigned PER_1S_MS    = 1000;
   localparam int unsigned PER_4S_MS    = 4000;
   localparam int unsigned PER_BYP_MS   = 120_000;
   localparam int unsigned FLASH_MS     = 500;
   localparam logic [6:0] LOAD_B1 = 7'h23; // 35 percent
   localparam logic [6:0] LOAD_B2 = 7'h37; // 55 percent
   localparam logic [6:0] LOAD_B3 = 7'h4b; // 75 percent
   localparam logic [6:0] LOAD_B4 = 7'h5f; // 95 percent
   localparam logic [6:0] LOAD_OVL = 7'h69; // 105 percent
   localparam logic [6:0] CAP_B1 = 7'h19; // 25 percent
   localparam logic [6:0] CAP_B2 = 7'h32; // 50 percent
   localparam logic [6:0] CAP_B3 = 7'h4b; // 75 percent
   localparam logic [6:0] CAP_B4 = 7'h5f; // 95 percent
   localparam logic [6:0] CAP_LOW = 7'h14; // 20 percent
   localparam logic [4:0] BAR_NONE = 5'h00;
   localparam int unsigned TW = 10;

   typedef struct packed {
      logic mains_ok;
      logic wiring_fault;
      logic on_inverter;
      logic on_bypass;
      logic on_battery;
      logic unit_on;
      logic fault;
      logic slot_board;
      logic [6:0] load_pct;
      logic [6:0] cap_pct;
   } upi_status_type;

   typedef struct packed {
      logic bypass;
      logic inverter;
      logic battery;
      logic mains;
      logic fault;
      logic [4:0] bar;
   } upi_leds_type;

   typedef enum logic [2:0] {
      ALM_NONE, ALM_BYPASS, ALM_BAT, ALM_BAT_LOW, ALM_OVERLOAD, ALM_FAULT
   } upi_alarm_type;
endpackage
`default_nettype wire
